// *** inc/hdlcc_pkg.sv ***
package hdlcc_pkg;
    // Line flag and stuffing
    localparam logic [7:0] HDLCC_FLAG = 8'h7E;
    localparam int HDLCC_STUFF_RUN = 5;
    localparam int HDLCC_ABORT_RUN = 7;
    // Frame length limits in bytes
    localparam int HDLCC_ADDR_MIN = 14;
    localparam int HDLCC_ADDR_MAX = 70;
    localparam int HDLCC_FCS_BYTES = 2;
    localparam int HDLCC_MIN_BYTES = HDLCC_ADDR_MIN + 1 + HDLCC_FCS_BYTES;
    // Check sequence
    localparam logic [15:0] HDLCC_FCS_INIT = 16'hFFFF;
    localparam logic [15:0] HDLCC_FCS_POLY = 16'h8408;
    localparam logic [15:0] HDLCC_FCS_GOOD = 16'hF0B8;
    // Control byte codes
    localparam logic [3:0] HDLCC_SUP_RR = 4'h1;
    localparam logic [3:0] HDLCC_SUP_RNR = 4'h5;
    localparam logic [3:0] HDLCC_SUP_REJ = 4'h9;
    localparam logic [7:0] HDLCC_CTL_UI = 8'h03;
    localparam logic [7:0] HDLCC_CTL_DM = 8'h0F;
    localparam logic [7:0] HDLCC_CTL_SABM = 8'h2F;
    localparam logic [7:0] HDLCC_CTL_DISC = 8'h43;
    localparam logic [7:0] HDLCC_CTL_UA = 8'h63;
    localparam logic [7:0] HDLCC_CTL_FRMR = 8'h87;
    localparam logic [7:0] HDLCC_PID_NONE = 8'hF0;
    // Sequence numbers
    localparam int HDLCC_SEQ_W = 3;
    localparam int HDLCC_MAX_OUT = 7;
    // Clock recovery: samples per bit
    localparam int HDLCC_OVS = 8;
    // Frame classes
    typedef enum logic [3:0] {
        HDLCC_K_I, HDLCC_K_RR, HDLCC_K_RNR, HDLCC_K_REJ, HDLCC_K_UI,
        HDLCC_K_DM, HDLCC_K_SABM, HDLCC_K_DISC, HDLCC_K_UA, HDLCC_K_FRMR,
        HDLCC_K_UNK
    } hdlcc_kind_e;
endpackage : hdlcc_pkg

// *** inc/hdlcc_bit_if.sv ***
`timescale 1ns/1ps
// Recovered bit stream from line front end to deframer
interface hdlcc_bit_if;
    logic valid;
    logic bitVal;
    modport src (output valid, output bitVal);
    modport dst (input valid, input bitVal);
endinterface : hdlcc_bit_if

// *** rtl/hdlcc_rx_front.sv ***
`timescale 1ns/1ps
// Oversampled NRZI receive front end with transition-locked bit clock
module hdlcc_rx_front
    import hdlcc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic clkEn,
    // Line sample
    input wire logic rxLine,
    // Recovered bits
    hdlcc_bit_if.src bits
);
    import hdlcc_pkg::*;
    localparam logic [3:0] PH_MAX = 4'(HDLCC_OVS - 1);
    localparam logic [3:0] PH_MID = 4'(HDLCC_OVS / 2);
    logic lineR_r, lineR_nxt, prevLvl_r, prevLvl_nxt;
    logic [3:0] phase_r, phase_nxt;
    logic valid_r, valid_nxt, bit_r, bit_nxt;

    // Phase reset on transition, decode at bit centre
    always_comb
    begin
        lineR_nxt = rxLine;
        phase_nxt = (phase_r == PH_MAX) ? 4'h0 : phase_r + 4'h1;
        prevLvl_nxt = prevLvl_r;
        valid_nxt = 1'b0;
        bit_nxt = bit_r;
        if (rxLine != lineR_r)
            phase_nxt = 4'h0;
        if (phase_r == PH_MID)
        begin
            valid_nxt = 1'b1;
            bit_nxt = (lineR_r == prevLvl_r);
            prevLvl_nxt = lineR_r;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            lineR_r <= 1'b1;
            prevLvl_r <= 1'b1;
            phase_r <= 4'h0;
            valid_r <= 1'b0;
            bit_r <= 1'b0;
        end
        else if (clkEn)
        begin
            lineR_r <= lineR_nxt;
            prevLvl_r <= prevLvl_nxt;
            phase_r <= phase_nxt;
            valid_r <= valid_nxt;
            bit_r <= bit_nxt;
        end
    end

    assign bits.valid = valid_r;
    assign bits.bitVal = bit_r;
endmodule : hdlcc_rx_front

// *** rtl/hdlcc_codec.sv ***
`timescale 1ns/1ps
module hdlcc_codec
    import hdlcc_pkg::*;
#(
    parameter int TX_BIT_DIV = HDLCC_OVS,
    parameter logic [2:0] MAX_OUTSTANDING_FRAMES = 3'(HDLCC_MAX_OUT)
)(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic clkEn,
    // Transmit bytes from host
    input wire logic txValid,
    input wire logic [7:0] txData,
    input wire logic txLast,
    output logic txReady,
    // Receive bytes to host
    output logic rxValid,
    output logic [7:0] rxData,
    output logic rxEnd,
    output logic rxGood,
    output logic rxErr,
    output logic [3:0] rxKind,
    output logic [2:0] rxNs,
    output logic [2:0] rxNr,
    output logic rxPidOk,
    output logic [2:0] maxOut,
    // Line
    input wire logic rxLine,
    output logic txLine
);
    import hdlcc_pkg::*;
    localparam logic [15:0] DIV_MAX = 16'(TX_BIT_DIV - 1);
    // Good residue once the closing flag's first seven bits have passed the checker
    localparam logic [15:0] FCS_AT_FLAG = 16'h4F85;

    // Transmit: bit timer, shifter, stuffing, FCS, NRZI
    typedef enum logic [2:0] {TX_IDLE, TX_OPEN, TX_DATA, TX_FCS, TX_CLOSE} hdlcc_tx_e;
    hdlcc_tx_e txSt_r, txSt_nxt;
    logic [15:0] div_r, div_nxt;
    logic [7:0] txSh_r, txSh_nxt;
    logic [3:0] txCnt_r, txCnt_nxt;
    logic [2:0] txOnes_r, txOnes_nxt;
    logic [15:0] txFcs_r, txFcs_nxt;
    logic txLast_r, txLast_nxt, txLine_r, txLine_nxt, txReady_r, txReady_nxt;
    logic tick, curBit, stuffNow;

    always_comb
    begin
        tick = (div_r == DIV_MAX);
        div_nxt = tick ? 16'h0 : div_r + 16'h1;
        txSt_nxt = txSt_r;
        txSh_nxt = txSh_r;
        txCnt_nxt = txCnt_r;
        txOnes_nxt = txOnes_r;
        txFcs_nxt = txFcs_r;
        txLast_nxt = txLast_r;
        txLine_nxt = txLine_r;
        txReady_nxt = 1'b0;
        curBit = txSh_r[0];
        stuffNow = (txSt_r == TX_DATA || txSt_r == TX_FCS
            || (txSt_r == TX_CLOSE && txCnt_r == 4'h0)) && txOnes_r == 3'(HDLCC_STUFF_RUN);
        if (txSt_r == TX_IDLE)
        begin
            if (txValid)
            begin
                txSt_nxt = TX_OPEN;
                txSh_nxt = HDLCC_FLAG;
                txCnt_nxt = 4'h0;
            end
        end
        else if (tick)
        begin
            if (stuffNow)
            begin
                txLine_nxt = !txLine_r;
                txOnes_nxt = 3'h0;
            end
            else
            begin
                if (!curBit)
                    txLine_nxt = !txLine_r;
                if (txSt_r == TX_DATA || txSt_r == TX_FCS)
                    txOnes_nxt = curBit ? txOnes_r + 3'h1 : 3'h0;
                if (txSt_r == TX_DATA)
                    txFcs_nxt = (txFcs_r >> 1) ^
                        (((txFcs_r[0] ^ curBit)) ? HDLCC_FCS_POLY : 16'h0);
                txSh_nxt = {1'b0, txSh_r[7:1]};
                txCnt_nxt = txCnt_r + 4'h1;
                if (txCnt_r == 4'h7 || (txSt_r == TX_FCS && txCnt_r == 4'hF))
                begin
                    unique case (txSt_r)
                        TX_OPEN:
                        begin
                            txSt_nxt = TX_DATA;
                            txSh_nxt = txData;
                            txLast_nxt = txLast;
                            txFcs_nxt = HDLCC_FCS_INIT;
                            txOnes_nxt = 3'h0;
                            txCnt_nxt = 4'h0;
                        end
                        TX_DATA:
                        begin
                            txCnt_nxt = 4'h0;
                            if (txLast_r)
                            begin
                                txSt_nxt = TX_FCS;
                                txSh_nxt = ~txFcs_nxt[7:0];
                            end
                            else
                            begin
                                txSh_nxt = txData;
                                txLast_nxt = txLast;
                            end
                        end
                        TX_FCS:
                            if (txCnt_r == 4'h7)
                                txSh_nxt = ~txFcs_r[15:8];
                            else
                            begin
                                txSt_nxt = TX_CLOSE;
                                txSh_nxt = HDLCC_FLAG;
                                txCnt_nxt = 4'h0;
                            end
                        TX_CLOSE:
                            txSt_nxt = TX_IDLE;
                        default:
                            txSt_nxt = TX_IDLE;
                    endcase
                    // Next data byte taken on load
                    txReady_nxt = (txSt_r == TX_OPEN) || (txSt_r == TX_DATA && !txLast_r);
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            txSt_r <= TX_IDLE;
            div_r <= 16'h0;
            txSh_r <= 8'h00;
            txCnt_r <= 4'h0;
            txOnes_r <= 3'h0;
            txFcs_r <= HDLCC_FCS_INIT;
            txLast_r <= 1'b0;
            txLine_r <= 1'b1;
            txReady_r <= 1'b0;
        end
        else if (clkEn)
        begin
            txSt_r <= txSt_nxt;
            div_r <= div_nxt;
            txSh_r <= txSh_nxt;
            txCnt_r <= txCnt_nxt;
            txOnes_r <= txOnes_nxt;
            txFcs_r <= txFcs_nxt;
            txLast_r <= txLast_nxt;
            txLine_r <= txLine_nxt;
            txReady_r <= txReady_nxt;
        end
    end

    // Receive front end
    hdlcc_bit_if rxBits ();
    hdlcc_rx_front uFront (
        .clock(clock),
        .rstn(rstn),
        .clkEn(clkEn),
        .rxLine(rxLine),
        .bits(rxBits)
    );

    // Receive deframer: flag hunt, destuff, FCS, classify
    logic [7:0] hist_r, hist_nxt, rSh_r, rSh_nxt, ctl_r, ctl_nxt;
    logic [7:0] pend_r, pend_nxt, older_r, older_nxt, out_r, out_nxt;
    logic [2:0] rCnt_r, rCnt_nxt, rOnes_r, rOnes_nxt;
    logic [15:0] rFcs_r, rFcs_nxt;
    logic [7:0] len_r, len_nxt;
    logic inFrame_r, inFrame_nxt, addrEnd_r, addrEnd_nxt;
    logic bad_r, bad_nxt, oV_r, oV_nxt, oEnd_r, oEnd_nxt, oGood_r, oGood_nxt;
    logic oErr_r, oErr_nxt, pidOk_r, pidOk_nxt, pidDue_r, pidDue_nxt;
    logic [3:0] kind_r, kind_nxt;
    logic [2:0] ns_r, ns_nxt, nr_r, nr_nxt;
    logic [7:0] h, byteNow;

    always_comb
    begin
        hist_nxt = hist_r;
        rSh_nxt = rSh_r;
        ctl_nxt = ctl_r;
        pend_nxt = pend_r;
        older_nxt = older_r;
        out_nxt = out_r;
        rCnt_nxt = rCnt_r;
        rOnes_nxt = rOnes_r;
        rFcs_nxt = rFcs_r;
        len_nxt = len_r;
        inFrame_nxt = inFrame_r;
        addrEnd_nxt = addrEnd_r;
        pidDue_nxt = pidDue_r;
        bad_nxt = bad_r;
        oV_nxt = 1'b0;
        oEnd_nxt = 1'b0;
        oGood_nxt = 1'b0;
        oErr_nxt = 1'b0;
        pidOk_nxt = pidOk_r;
        kind_nxt = kind_r;
        ns_nxt = ns_r;
        nr_nxt = nr_r;
        h = {rxBits.bitVal, hist_r[7:1]};
        byteNow = {rxBits.bitVal, rSh_r[7:1]};
        if (rxBits.valid)
        begin
            hist_nxt = h;
            rOnes_nxt = rxBits.bitVal ? rOnes_r + 3'h1 : 3'h0;
            if (h == HDLCC_FLAG)
            begin
                // Closing flag ends frame; check length and FCS
                if (inFrame_r && len_r != 8'h0)
                begin
                    oEnd_nxt = 1'b1;
                    if (bad_r || len_r < 8'(HDLCC_MIN_BYTES) || rCnt_r != 3'h7
                        || rFcs_r != FCS_AT_FLAG)
                        oErr_nxt = 1'b1;
                    else
                        oGood_nxt = 1'b1;
                end
                inFrame_nxt = 1'b1;
                len_nxt = 8'h0;
                rCnt_nxt = 3'h0;
                rOnes_nxt = 3'h0;
                rFcs_nxt = HDLCC_FCS_INIT;
                bad_nxt = 1'b0;
                addrEnd_nxt = 1'b0;
                pidDue_nxt = 1'b0;
            end
            else if (rOnes_r == 3'(HDLCC_ABORT_RUN - 1) && rxBits.bitVal)
            begin
                inFrame_nxt = 1'b0;
                if (len_r != 8'h0)
                    oErr_nxt = 1'b1;
                len_nxt = 8'h0;
            end
            else if (inFrame_r && rOnes_r == 3'(HDLCC_STUFF_RUN) && !rxBits.bitVal)
                rOnes_nxt = 3'h0;
            else if (inFrame_r)
            begin
                rSh_nxt = byteNow;
                rCnt_nxt = rCnt_r + 3'h1;
                rFcs_nxt = (rFcs_r >> 1) ^
                    ((rFcs_r[0] ^ rxBits.bitVal) ? HDLCC_FCS_POLY : 16'h0);
                if (rCnt_r == 3'h7)
                begin
                    if (len_r != 8'hFF)
                        len_nxt = len_r + 8'h1;
                    // Delay output by two bytes so FCS never reaches host
                    pend_nxt = byteNow;
                    older_nxt = pend_r;
                    pidDue_nxt = 1'b0;
                    if (len_r >= 8'h2)
                    begin
                        oV_nxt = 1'b1;
                        out_nxt = older_r;
                    end
                    if (len_r >= 8'h2 && len_r < 8'(HDLCC_ADDR_MAX + 2))
                    begin
                        // Address ends on a byte with its low bit set
                        if (!addrEnd_r && pend_r[0] && len_r >= 8'(HDLCC_ADDR_MIN))
                            addrEnd_nxt = 1'b1;
                    end
                    else if (len_r >= 8'(HDLCC_ADDR_MAX + 2) && !addrEnd_r)
                        bad_nxt = 1'b1;
                    if (addrEnd_r && ctl_r == 8'h00 && kind_r == 4'(HDLCC_K_UNK))
                    begin
                        ctl_nxt = pend_r;
                        ns_nxt = pend_r[3:1];
                        nr_nxt = pend_r[7:5];
                        if (!pend_r[0])
                            kind_nxt = 4'(HDLCC_K_I);
                        else if (pend_r[3:0] == HDLCC_SUP_RR)
                            kind_nxt = 4'(HDLCC_K_RR);
                        else if (pend_r[3:0] == HDLCC_SUP_RNR)
                            kind_nxt = 4'(HDLCC_K_RNR);
                        else if (pend_r[3:0] == HDLCC_SUP_REJ)
                            kind_nxt = 4'(HDLCC_K_REJ);
                        else if (pend_r == HDLCC_CTL_UI)
                            kind_nxt = 4'(HDLCC_K_UI);
                        else if (pend_r == HDLCC_CTL_DM)
                            kind_nxt = 4'(HDLCC_K_DM);
                        else if (pend_r == HDLCC_CTL_SABM)
                            kind_nxt = 4'(HDLCC_K_SABM);
                        else if (pend_r == HDLCC_CTL_DISC)
                            kind_nxt = 4'(HDLCC_K_DISC);
                        else if (pend_r == HDLCC_CTL_UA)
                            kind_nxt = 4'(HDLCC_K_UA);
                        else if (pend_r == HDLCC_CTL_FRMR)
                            kind_nxt = 4'(HDLCC_K_FRMR);
                        else
                            kind_nxt = 4'(HDLCC_K_UNK);
                        pidDue_nxt = 1'b1;
                    end
                    // Identifier follows control in I and UI frames
                    if (pidDue_r && (kind_r == 4'(HDLCC_K_I) || kind_r == 4'(HDLCC_K_UI)))
                        pidOk_nxt = (pend_r == HDLCC_PID_NONE);
                end
            end
            if (len_r == 8'h0 && len_nxt == 8'h1)
            begin
                kind_nxt = 4'(HDLCC_K_UNK);
                ctl_nxt = 8'h00;
                pidOk_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            hist_r <= 8'h00;
            rSh_r <= 8'h00;
            ctl_r <= 8'h00;
            pend_r <= 8'h00;
            older_r <= 8'h00;
            out_r <= 8'h00;
            rCnt_r <= 3'h0;
            rOnes_r <= 3'h0;
            rFcs_r <= HDLCC_FCS_INIT;
            len_r <= 8'h0;
            inFrame_r <= 1'b0;
            addrEnd_r <= 1'b0;
            pidDue_r <= 1'b0;
            bad_r <= 1'b0;
            oV_r <= 1'b0;
            oEnd_r <= 1'b0;
            oGood_r <= 1'b0;
            oErr_r <= 1'b0;
            pidOk_r <= 1'b0;
            kind_r <= 4'(HDLCC_K_UNK);
            ns_r <= 3'h0;
            nr_r <= 3'h0;
        end
        else if (clkEn)
        begin
            hist_r <= hist_nxt;
            rSh_r <= rSh_nxt;
            ctl_r <= ctl_nxt;
            pend_r <= pend_nxt;
            older_r <= older_nxt;
            out_r <= out_nxt;
            rCnt_r <= rCnt_nxt;
            rOnes_r <= rOnes_nxt;
            rFcs_r <= rFcs_nxt;
            len_r <= len_nxt;
            inFrame_r <= inFrame_nxt;
            addrEnd_r <= addrEnd_nxt;
            pidDue_r <= pidDue_nxt;
            bad_r <= bad_nxt;
            oV_r <= oV_nxt;
            oEnd_r <= oEnd_nxt;
            oGood_r <= oGood_nxt;
            oErr_r <= oErr_nxt;
            pidOk_r <= pidOk_nxt;
            kind_r <= kind_nxt;
            ns_r <= ns_nxt;
            nr_r <= nr_nxt;
        end
    end

    // Outputs straight from registers, except maxOut, which is the MAX_OUTSTANDING_FRAMES parameter
    assign txReady = txReady_r;
    assign txLine = txLine_r;
    assign rxValid = oV_r;
    assign rxData = out_r;
    assign rxEnd = oEnd_r;
    assign rxGood = oGood_r;
    assign rxErr = oErr_r;
    assign rxKind = kind_r;
    assign rxNs = ns_r;
    assign rxNr = nr_r;
    assign rxPidOk = pidOk_r;
    assign maxOut = MAX_OUTSTANDING_FRAMES;
endmodule : hdlcc_codec

// *** tb/hdlcc_codec_sva.sv ***
`timescale 1ns/1ps
// Port-level checks of the codec
module hdlcc_codec_sva
    import hdlcc_pkg::*;
#(
    parameter int TX_BIT_DIV = HDLCC_OVS,
    parameter logic [2:0] MAX_OUTSTANDING_FRAMES = 3'(HDLCC_MAX_OUT)
)(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Observed outputs
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic rxEnd,
    input wire logic rxGood,
    input wire logic rxErr,
    input wire logic [3:0] rxKind,
    input wire logic [2:0] rxNs,
    input wire logic [2:0] rxNr,
    input wire logic rxPidOk,
    input wire logic [2:0] maxOut,
    input wire logic txLine
);
    logic [7:0] gap_r, gap_nxt, cnt_r, cnt_nxt, ctl_r, ctl_nxt, pid_r, pid_nxt;
    logic last_r, goodEnd;
    logic [7:0] ctlAt_r, ctlAt_nxt;
    // Expected class of a control byte
    function automatic logic [3:0] kind_of(input logic [7:0] c);
        if (!c[0])
            return HDLCC_K_I;
        case (c[3:0])
            HDLCC_SUP_RR: return HDLCC_K_RR;
            HDLCC_SUP_RNR: return HDLCC_K_RNR;
            HDLCC_SUP_REJ: return HDLCC_K_REJ;
            default: ;
        endcase
        case (c)
            HDLCC_CTL_UI: return HDLCC_K_UI;
            HDLCC_CTL_DM: return HDLCC_K_DM;
            HDLCC_CTL_SABM: return HDLCC_K_SABM;
            HDLCC_CTL_DISC: return HDLCC_K_DISC;
            HDLCC_CTL_UA: return HDLCC_K_UA;
            HDLCC_CTL_FRMR: return HDLCC_K_FRMR;
            default: return HDLCC_K_UNK;
        endcase
    endfunction : kind_of
    // Line spacing, delivered byte count, control and identifier capture
    always_comb
    begin
        gap_nxt = (txLine != last_r) ? 8'h01 : gap_r + 8'(gap_r != 8'hFF);
        cnt_nxt = (rxEnd || rxErr) ? 8'h00 : cnt_r + 8'(rxValid);
        ctlAt_nxt = (rxEnd || rxErr) ? 8'hFF : (rxValid && rxData[0] && &ctlAt_r) ? cnt_r + 8'h1 : ctlAt_r;
        ctl_nxt = (rxValid && cnt_r == ctlAt_r) ? rxData : ctl_r;
        pid_nxt = (rxValid && cnt_r == ctlAt_r + 8'h1) ? rxData : pid_r;
    end
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            gap_r <= 8'hFF;
            last_r <= 1'b1;
            cnt_r <= 8'h00;
            ctl_r <= 8'h00;
            ctlAt_r <= 8'hFF;
            pid_r <= 8'h00;
        end
        else
        begin
            gap_r <= gap_nxt;
            last_r <= txLine;
            cnt_r <= cnt_nxt;
            ctl_r <= ctl_nxt;
            ctlAt_r <= ctlAt_nxt;
            pid_r <= pid_nxt;
        end
    end
    assign goodEnd = rxEnd && rxGood;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    line_gap_a: assert property ((txLine != last_r) |-> gap_r >= 8'(TX_BIT_DIV))
        else $error("txLine changed inside a bit period");
    one_verdict_a: assert property (rxEnd |-> (rxGood != rxErr))
        else $error("frame end without a single verdict");
    end_pulse_a: assert property (rxEnd |=> !rxEnd)
        else $error("frame end longer than one cycle");
    kind_decode_a: assert property (goodEnd |-> rxKind == kind_of(ctl_r))
        else $error("frame class does not match control byte");
    info_seq_a: assert property (goodEnd && !ctl_r[0] |-> rxNs == ctl_r[3:1] && rxNr == ctl_r[7:5])
        else $error("information frame numbers wrong");
    pid_flag_a: assert property (goodEnd && cnt_r > ctlAt_r + 8'h1
        && (ctl_r == HDLCC_CTL_UI || !ctl_r[0]) |-> rxPidOk == (pid_r == HDLCC_PID_NONE))
        else $error("protocol identifier flag wrong");
    short_err_a: assert property (rxEnd && cnt_r < 8'(HDLCC_ADDR_MIN + 1) |-> rxErr && !rxGood)
        else $error("short frame not refused");
    max_out_a: assert property (maxOut == MAX_OUTSTANDING_FRAMES)
        else $error("outstanding limit output wrong");
    cover property (goodEnd && !ctl_r[0]);
    cover property (rxEnd && rxErr);
    cover property (rxErr && !rxEnd);
endmodule : hdlcc_codec_sva

bind hdlcc_codec hdlcc_codec_sva #(
    .TX_BIT_DIV(TX_BIT_DIV),
    .MAX_OUTSTANDING_FRAMES(MAX_OUTSTANDING_FRAMES)
) chk (
    .clock(clock), .rstn(rstn), .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd),
    .rxGood(rxGood), .rxErr(rxErr), .rxKind(rxKind), .rxNs(rxNs), .rxNr(rxNr),
    .rxPidOk(rxPidOk), .maxOut(maxOut), .txLine(txLine)
);

// *** tb/hdlcc_line_model.sv ***
`timescale 1ns/1ps
// Channel stand-in: delays the line, inverts or freezes it on command
module hdlcc_line_model #(
    parameter int BIT_CLKS = 8
)(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Line in and fault command: 1 inverts a bit, 2 freezes ten bits
    input wire logic txLine,
    input wire logic [1:0] fault,
    // Line out
    output logic rxLine
);
    logic [3:0] dly_r, dly_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic inv_r, inv_nxt, line_nxt;
    // Delay and fault shaping
    always_comb
    begin
        dly_nxt = {dly_r[2:0], txLine}; // Phase offset to the receiver
        cnt_nxt = (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
        inv_nxt = inv_r;
        line_nxt = dly_r[3]; // Line level and bit order passed as sent
        if (fault != 2'h0)
        begin
            cnt_nxt = 8'((fault == 2'h1) ? BIT_CLKS : 10 * BIT_CLKS);
            inv_nxt = (fault == 2'h1);
        end
        if (cnt_r != 8'h00)
            line_nxt = inv_r ? ~dly_r[3] : rxLine;
    end
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            dly_r <= 4'hF;
            cnt_r <= 8'h00;
            inv_r <= 1'b0;
            rxLine <= 1'b1;
        end
        else
        begin
            dly_r <= dly_nxt;
            cnt_r <= cnt_nxt;
            inv_r <= inv_nxt;
            rxLine <= line_nxt;
        end
    end
endmodule : hdlcc_line_model

// *** tb/hdlcc_codec_test.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checkCount++; if ((got) !== (exp)) begin nErrors++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
// Loopback bench through the channel model
module hdlcc_codec_test;
    import hdlcc_pkg::*;
    typedef logic [7:0] hdlcc_byteq_t[$];
    localparam logic [2:0] MAXO = 3'h4;
    logic clock, rstn, clkEn, txValid, txLast, txReady, rxValid, rxEnd, rxGood, rxErr;
    logic rxPidOk, rxLine, txLine, gotGood, gotErr, gotEnd;
    logic [7:0] txData, rxData;
    logic [3:0] rxKind;
    logic [2:0] rxNs, rxNr, maxOut;
    logic [1:0] fault;
    logic [7:0] rxq[$];
    int nErrors = 0, checkCount = 0;
    logic [7:0] ctls[13] = '{8'h03, 8'h0F, 8'h2F, 8'h43, 8'h63, 8'h87, 8'hA1, 8'h25, 8'hE9,
        8'hB4, 8'h5A, 8'hEC, 8'h3E};
    hdlcc_kind_e kinds[13] = '{HDLCC_K_UI, HDLCC_K_DM, HDLCC_K_SABM, HDLCC_K_DISC, HDLCC_K_UA,
        HDLCC_K_FRMR, HDLCC_K_RR, HDLCC_K_RNR, HDLCC_K_REJ, HDLCC_K_I, HDLCC_K_I, HDLCC_K_I,
        HDLCC_K_I};
    hdlcc_codec #(.MAX_OUTSTANDING_FRAMES(MAXO)) dut (
        .clock(clock), .rstn(rstn), .clkEn(clkEn), .txValid(txValid), .txData(txData),
        .txLast(txLast), .txReady(txReady), .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd),
        .rxGood(rxGood), .rxErr(rxErr), .rxKind(rxKind), .rxNs(rxNs), .rxNr(rxNr),
        .rxPidOk(rxPidOk), .maxOut(maxOut), .rxLine(rxLine), .txLine(txLine));
    hdlcc_line_model far (.clock(clock), .rstn(rstn), .txLine(txLine), .fault(fault),
        .rxLine(rxLine));
    // Clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Delivered bytes and verdicts
    always @(posedge clock)
    begin
        if (rxValid === 1'b1) rxq.push_back(rxData);
        if (rxEnd === 1'b1) gotEnd = 1'b1;
        if (rxGood === 1'b1) gotGood = 1'b1;
        if (rxErr === 1'b1) gotErr = 1'b1;
    end
    task automatic finalReport;
        $display("Checks %0d, errors %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finalReport
    // Frame of address bytes, control, optional identifier and payload
    function automatic hdlcc_byteq_t mkFrame(int nAddr, logic [7:0] ctl, logic [7:0] pid, bit info);
        hdlcc_byteq_t fr;
        for (int i = 0; i < nAddr; i++)
            fr.push_back(8'h9C + 8'(2 * i) + 8'(i == nAddr - 1));
        fr.push_back(ctl);
        if (info)
            fr = {fr, pid, 8'hFF, 8'h7E, 8'h3C};
        return fr;
    endfunction : mkFrame
    task automatic sendFrame(hdlcc_byteq_t fr);
        int k;
        rxq.delete();
        gotEnd = 1'b0;
        gotGood = 1'b0;
        gotErr = 1'b0;
        foreach (fr[i])
        begin
            @(negedge clock);
            txValid = 1'b1;
            txData = fr[i];
            txLast = (i == fr.size() - 1);
            k = 0;
            while (txReady !== 1'b1 && k < 300)
            begin
                @(negedge clock);
                k++;
            end
            @(posedge clock);
        end
        @(negedge clock);
        txValid = 1'b0;
        txLast = 1'b0;
    endtask : sendFrame
    task automatic waitDone;
        int k = 0;
        while (!gotEnd && !gotErr && k < 3000)
        begin
            @(negedge clock);
            k++;
        end
        repeat (300) @(negedge clock);
    endtask : waitDone
    task automatic checkReset;
        `CHK("txLine idle", 1'b1, txLine)
        `CHK("maxOut", MAXO, maxOut)
        `CHK("rxKind", HDLCC_K_UNK, rxKind)
    endtask : checkReset
    task automatic kindFrames;
        hdlcc_byteq_t fr;
        bit info;
        for (int i = 0; i < 13; i++)
        begin
            info = (kinds[i] == HDLCC_K_I || kinds[i] == HDLCC_K_UI);
            fr = mkFrame(14, ctls[i], (i == 12) ? 8'hCF : 8'hF0, info);
            sendFrame(fr);
            waitDone();
            `CHK("good", 1'b1, gotGood)
            `CHK("count", fr.size(), rxq.size())
            foreach (fr[j]) `CHK("byte", fr[j], rxq[j])
            `CHK("kind", kinds[i], rxKind)
            if (info) `CHK("pidOk", (i != 12), rxPidOk)
            if (kinds[i] == HDLCC_K_I) `CHK("ns", ctls[i][3:1], rxNs)
            if (kinds[i] == HDLCC_K_I) `CHK("nr", ctls[i][7:5], rxNr)
        end
    endtask : kindFrames
    task automatic longAddr;
        hdlcc_byteq_t fr;
        fr = mkFrame(70, 8'h03, 8'hF0, 1'b1);
        sendFrame(fr);
        waitDone();
        `CHK("long good", 1'b1, gotGood)
        `CHK("long count", fr.size(), rxq.size())
    endtask : longAddr
    task automatic runBad(int nAddr, logic [1:0] f);
        fork
            sendFrame(mkFrame(nAddr, 8'h03, 8'hF0, nAddr > 10));
            if (f != 2'h0)
            begin
                repeat (600) @(negedge clock);
                fault = f;
                @(negedge clock);
                fault = 2'h0;
            end
        join
        waitDone();
    endtask : runBad
    task automatic badFcs;
        runBad(14, 2'h1);
        `CHK("fcs err", 1'b1, gotErr)
        `CHK("fcs good", 1'b0, gotGood)
    endtask : badFcs
    task automatic abortFrame;
        runBad(14, 2'h2);
        `CHK("abort err", 1'b1, gotErr)
        `CHK("abort good", 1'b0, gotGood)
    endtask : abortFrame
    task automatic shortFrame;
        runBad(10, 2'h0);
        `CHK("short err", 1'b1, gotErr)
        `CHK("short good", 1'b0, gotGood)
    endtask : shortFrame
    // Main sequence
    initial
    begin
        rstn = 1'b0;
        clkEn = 1'b1;
        txValid = 1'b0;
        txData = 8'h00;
        txLast = 1'b0;
        fault = 2'h0;
        repeat (8) @(negedge clock);
        rstn = 1'b1;
        @(negedge clock);
        checkReset();
        kindFrames();
        longAddr();
        badFcs();
        abortFrame();
        shortFrame();
        finalReport();
    end
    // Watchdog
    initial
    begin
        repeat (90000) @(posedge clock);
        nErrors++;
        finalReport();
    end
endmodule : hdlcc_codec_test
